// *** hw/test_point_pkg.sv ***
package test_point_pkg;
    // port width and capture field
    localparam int TP_WIDTH = 8;
    localparam int CAP_LO = 0;
    localparam int CAP_HI = 2;
    localparam int OPT_LO = 3;
    localparam int OPT_HI = 6;
    // capture values of the low field
    localparam logic [2:0] CAP_QUIET = 3'h0;
    localparam logic [2:0] CAP_CLOCK_DEBUG = 3'h2;
    // reset values
    localparam logic [7:0] STRAP_RESET = 8'h00;
    // clock debug frequencies in kHz against the 100 MHz master clock
    localparam int MCLK_KHZ = 100000;
    localparam int F0_KHZ = 60000;
    localparam int F1_KHZ = 30000;
    localparam int F7_KHZ = 7500;
    localparam int VAR_MIN_KHZ = 700;
    localparam int VAR_MAX_KHZ = 22500;
    // phase accumulator width for the synthesized debug clocks
    localparam int ACC_W = 24;
    // phase increments: f / fclk scaled to 2^ACC_W
    localparam logic [23:0] INC_F0 = 24'((64'(F0_KHZ) << ACC_W) / MCLK_KHZ);
    localparam logic [23:0] INC_F1 = 24'((64'(F1_KHZ) << ACC_W) / MCLK_KHZ);
    localparam logic [23:0] INC_F7 = 24'((64'(F7_KHZ) << ACC_W) / MCLK_KHZ);
    localparam logic [23:0] INC_VMIN = 24'((64'(VAR_MIN_KHZ) << ACC_W) / MCLK_KHZ);
    localparam logic [23:0] INC_VMAX = 24'((64'(VAR_MAX_KHZ) << ACC_W) / MCLK_KHZ);
    // output source selectors per pin
    typedef enum logic [2:0] {
        SRC_HIZ = 3'h0,
        SRC_LOW = 3'h1,
        SRC_HIGH = 3'h2,
        SRC_CLK_A = 3'h3,
        SRC_CLK_B = 3'h4,
        SRC_CLK_VAR = 3'h5,
        SRC_CLK_C = 3'h6,
        SRC_USER = 3'h7
    } pin_src_t;
endpackage

// *** hw/debug_clock_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
module debug_clock_gen
    import test_point_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [ACC_W-1:0] i_var_inc,
    output logic o_clk_a,
    output logic o_clk_b,
    output logic o_clk_var,
    output logic o_clk_c
);
    logic [ACC_W-1:0] acc_a_q;
    logic [ACC_W-1:0] acc_b_q;
    logic [ACC_W-1:0] acc_v_q;
    logic [ACC_W-1:0] acc_c_q;
    logic [ACC_W-1:0] var_inc_d;

    // clamp the variable clock into its allowed band
    assign var_inc_d = (i_var_inc < INC_VMIN) ? INC_VMIN :
                       (i_var_inc > INC_VMAX) ? INC_VMAX : i_var_inc;

    // phase accumulators; the msb is the clock, jitter of one master period is accepted
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            acc_a_q <= '0;
            acc_b_q <= '0;
            acc_v_q <= '0;
            acc_c_q <= '0;
        end
        else
        begin
            acc_a_q <= acc_a_q + INC_F0;
            acc_b_q <= acc_b_q + INC_F1;
            acc_v_q <= acc_v_q + var_inc_d;
            acc_c_q <= acc_c_q + INC_F7;
        end
    end

    assign o_clk_a = acc_a_q[ACC_W-1];
    assign o_clk_b = acc_b_q[ACC_W-1];
    assign o_clk_var = acc_v_q[ACC_W-1];
    assign o_clk_c = acc_c_q[ACC_W-1];
endmodule
`default_nettype wire

// *** hw/test_point_strap_config.sv ***
// Function
// - pins are inputs in reset; after it, only pins given a non-HIZ source drive
// - sample straps only on reset release edge
// - captured mode holds through reset until next release
// - undriven reads zero; x000 keeps pins tri-stated
// - x010 drives clock debug pattern on pins
// - bits six to three select operating option
// - software may reselect outputs after reset
`timescale 1ns/10ps
`default_nettype none
module test_point_strap_config
    import test_point_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_system_reset_n,
    input wire logic [TP_WIDTH-1:0] i_test_point_port,
    output logic [TP_WIDTH-1:0] o_test_point_port,
    output logic [TP_WIDTH-1:0] o_test_point_port_oe,
    input wire logic i_sel_wr,
    input wire logic [2:0] i_sel_pin,
    input wire logic [2:0] i_sel_src,
    input wire logic [TP_WIDTH-1:0] i_user_level,
    input wire logic [ACC_W-1:0] i_var_inc,
    output logic o_ports_live,
    output logic [TP_WIDTH-1:0] o_strap_value,
    output logic [OPT_HI-OPT_LO:0] o_mode_option
);
    logic [2:0] rst_sync_q;
    logic [TP_WIDTH-1:0] pin_s1_q;
    logic [TP_WIDTH-1:0] pin_s2_q;
    logic [TP_WIDTH-1:0] pin_s3_q;
    logic live_q;
    logic [TP_WIDTH-1:0] strap_q;
    logic [2:0] src_q [TP_WIDTH];
    logic [TP_WIDTH-1:0] out_q;
    logic [TP_WIDTH-1:0] oe_q;
    logic rst_released;
    logic rst_held;
    logic clk_a;
    logic clk_b;
    logic clk_var;
    logic clk_c;
    logic [TP_WIDTH-1:0] pins_clean;

    // default source for one pin, given the captured low field
    function automatic logic [2:0] default_src(input logic [2:0] cap, input int pin);
        logic [2:0] s;
        s = SRC_HIZ;
        if (cap == CAP_CLOCK_DEBUG)
        begin
            unique case (pin)
                0: s = SRC_CLK_A;
                1: s = SRC_CLK_B;
                2: s = SRC_CLK_VAR;
                4: s = SRC_LOW;
                7: s = SRC_CLK_C;
                default: s = SRC_HIGH;
            endcase
        end
        return s;
    endfunction

    debug_clock_gen u_clk
    (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_var_inc(i_var_inc),
        .o_clk_a(clk_a),
        .o_clk_b(clk_b),
        .o_clk_var(clk_var),
        .o_clk_c(clk_c)
    );

    // system reset pin and strap pins pass three flops; a level counts once stages 2 and 3 agree
    assign rst_released = rst_sync_q[1] & rst_sync_q[2] & ~live_q;
    assign rst_held = ~rst_sync_q[1] & ~rst_sync_q[2];
    // a strap pin counts as high only when stages 2 and 3 both hold it high; an x or z on both stays x
    assign pins_clean = pin_s2_q & pin_s3_q;

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            rst_sync_q <= 3'h0;
            pin_s1_q <= STRAP_RESET;
            pin_s2_q <= STRAP_RESET;
            pin_s3_q <= STRAP_RESET;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[1:0], i_system_reset_n};
            pin_s1_q <= i_test_point_port;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // capture once per reset release; later strap changes are ignored
    always_ff @(posedge i_mclk)
    begin
        if (i_reset || rst_held)
        begin
            live_q <= 1'b0;
            strap_q <= strap_q;
        end
        else if (rst_released)
        begin
            live_q <= 1'b1;
            strap_q <= pins_clean;
        end
    end

    // per-pin source selects: strap defaults at release, software may override later
    for (genvar p = 0; p < TP_WIDTH; p++)
    begin : g_pin
        always_ff @(posedge i_mclk)
        begin
            if (i_reset || rst_held)
                src_q[p] <= SRC_HIZ;
            else if (rst_released)
                src_q[p] <= default_src(pins_clean[CAP_HI:CAP_LO], p);
            else if (live_q && i_sel_wr && i_sel_pin == 3'(p))
                src_q[p] <= i_sel_src;
        end

        // pin value and enable registered so the port does not glitch
        always_ff @(posedge i_mclk)
        begin
            if (i_reset || !live_q)
            begin
                out_q[p] <= 1'b0;
                oe_q[p] <= 1'b0;
            end
            else
            begin
                unique case (src_q[p])
                    SRC_LOW: out_q[p] <= 1'b0;
                    SRC_HIGH: out_q[p] <= 1'b1;
                    SRC_CLK_A: out_q[p] <= clk_a;
                    SRC_CLK_B: out_q[p] <= clk_b;
                    SRC_CLK_VAR: out_q[p] <= clk_var;
                    SRC_CLK_C: out_q[p] <= clk_c;
                    SRC_USER: out_q[p] <= i_user_level[p];
                    default: out_q[p] <= 1'b0;
                endcase
                oe_q[p] <= (src_q[p] != SRC_HIZ);
            end
        end
    end

    assign o_test_point_port = out_q;
    assign o_test_point_port_oe = oe_q;
    assign o_ports_live = live_q;
    assign o_strap_value = strap_q;
    // the option field steers the wider controller
    assign o_mode_option = strap_q[OPT_HI:OPT_LO];
endmodule
`default_nettype wire

// *** verif/strap_board.sv ***
`timescale 1ns/10ps
`default_nettype none
// board side: jumpers lift the low pins, bench probes set the high ones
module strap_board
(
    input wire logic [2:0] i_jumpers,
    input wire logic [4:0] i_probes,
    input wire logic [7:0] i_dev_out,
    input wire logic [7:0] i_dev_oe,
    output logic [7:0] o_pin
);
    // a released pin falls to its pulldown unless lifted
    assign o_pin = (i_dev_oe & i_dev_out) | (~i_dev_oe & {i_probes, i_jumpers});
endmodule
`default_nettype wire

// *** verif/tpsc_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module tpsc_checker
    import test_point_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_system_reset_n,
    input wire logic [7:0] i_test_point_port,
    input wire logic [7:0] o_test_point_port,
    input wire logic [7:0] o_test_point_port_oe,
    input wire logic i_sel_wr,
    input wire logic [2:0] i_sel_pin,
    input wire logic [2:0] i_sel_src,
    input wire logic o_ports_live,
    input wire logic [7:0] o_strap_value,
    input wire logic [3:0] o_mode_option
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    // strap defaults only hold until software has touched a pin
    logic sw_q;
    logic live_q;
    always_ff @(posedge i_mclk)
    begin
        sw_q <= !i_reset && o_ports_live && (sw_q || i_sel_wr);
        live_q <= o_ports_live;
    end
    wire dflt = o_ports_live && live_q && !sw_q;
    wire dbg = dflt && o_strap_value[2:0] == CAP_CLOCK_DEBUG;
    // sync takes three edges, live drops on the fourth, enables follow one edge later
    a_reset_pins_input: assert property (!i_system_reset_n [*6] |->
        o_test_point_port_oe == 8'h00 && !o_ports_live) else $error("pins driven in reset");
    a_live_after_release: assert property ($rose(i_system_reset_n) |->
        !o_ports_live ##[3:6] o_ports_live) else $error("port not live after release");
    a_strap_capture: assert property ($rose(o_ports_live) |->
        o_strap_value == $past(i_test_point_port, 2)) else $error("strap capture wrong");
    a_strap_holds: assert property (live_q && o_ports_live |->
        $stable(o_strap_value) && $stable(o_mode_option)) else $error("strap changed");
    a_option_field: assert property (live_q && o_ports_live |->
        o_mode_option == o_strap_value[6:3]) else $error("option field wrong");
    a_quiet_hiz: assert property (dflt && o_strap_value[2:0] != CAP_CLOCK_DEBUG |->
        o_test_point_port_oe == 8'h00) else $error("quiet mode drives pins");
    a_debug_levels: assert property (dbg |-> o_test_point_port_oe == 8'hFF &&
        o_test_point_port[6:3] == 4'hD) else $error("debug levels wrong");
    a_fast_clock: assert property (dbg [*3] |-> !(o_test_point_port[0] == $past(
        o_test_point_port[0]) && o_test_point_port[0] == $past(o_test_point_port[0], 2)))
        else $error("fast debug clock stuck");
    a_select_drive: assert property (i_sel_wr && o_ports_live && i_sel_src inside {SRC_LOW,
        SRC_HIGH} |-> ##2 o_test_point_port_oe[$past(i_sel_pin, 2)] && o_test_point_port[
        $past(i_sel_pin, 2)] == ($past(i_sel_src, 2) == SRC_HIGH)) else $error("select lost");
    cover property (dbg [*3]);
    cover property ($rose(o_ports_live));
    cover property (i_sel_wr && o_ports_live);
endmodule
bind test_point_strap_config tpsc_checker i_chk (.i_mclk, .i_reset, .i_system_reset_n,
    .i_test_point_port, .o_test_point_port, .o_test_point_port_oe, .i_sel_wr, .i_sel_pin,
    .i_sel_src, .o_ports_live, .o_strap_value, .o_mode_option);
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
    import test_point_pkg::*;
    logic mclk = 1'h0, rst = 1'h1, sys_n = 1'h0, sel_wr = 1'h0, live;
    logic [2:0] jump = 3'h0, sel_pin = 3'h0, sel_src = 3'h0;
    logic [4:0] probe = 5'h00;
    logic [7:0] pin, out, oe, strap, user = 8'h00;
    logic [3:0] opt;
    int fails = 0, n_compared = 0;
    always #5 mclk = ~mclk;
    test_point_strap_config i_dut (.i_mclk(mclk), .i_reset(rst), .i_system_reset_n(sys_n),
        .i_test_point_port(pin), .o_test_point_port(out), .o_test_point_port_oe(oe),
        .i_sel_wr(sel_wr), .i_sel_pin(sel_pin), .i_sel_src(sel_src), .i_user_level(user),
        .i_var_inc(INC_VMAX), .o_ports_live(live), .o_strap_value(strap), .o_mode_option(opt));
    strap_board i_board (.i_jumpers(jump), .i_probes(probe), .i_dev_out(out), .i_dev_oe(oe),
        .o_pin(pin));
    task step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // system reset cycle with a given strap byte, then judge the capture
    task boot(input logic [7:0] s);
        sys_n = 1'h0;
        {probe, jump} = s;
        step(6);
        chk(oe, 8'h00);
        sys_n = 1'h1;
        step(8);
        chk({7'h00, live}, 8'h01);
        chk(strap, s);
        chk({4'h0, opt}, {4'h0, s[6:3]});
    endtask
    task sel(input logic [2:0] p, input logic [2:0] s);
        sel_pin = p;
        sel_src = s;
        sel_wr = 1'h1;
        step(1);
    endtask
    // option bits set, then straps moved after release must not count
    task quiet_modes;
        boot(8'h78);
        chk(oe, 8'h00);
        {probe, jump} = 8'h02;
        step(5);
        chk(strap, 8'h78);
        chk(oe, 8'h00);
        boot(8'h05);
        chk(oe, 8'h00);
    endtask
    // debug pattern, then back-to-back reselects, then a write refused in reset
    task clock_debug;
        boot(8'h02);
        chk(oe, 8'hFF);
        chk(out & 8'h78, 8'h68);
        sel(3'h4, SRC_HIGH);
        sel(3'h3, SRC_LOW);
        sel(3'h5, SRC_USER);
        sel(3'h7, SRC_HIZ);
        sel_wr = 1'h0;
        step(3);
        chk(oe, 8'h7F);
        chk(out & 8'h38, 8'h10);
        sys_n = 1'h0;
        step(6);
        sel(3'h0, SRC_HIGH);
        sel_wr = 1'h0;
        step(3);
        chk(oe, 8'h00);
    endtask
    initial
    begin
        step(8);
        rst = 1'h0;
        quiet_modes;
        clock_debug;
        report_and_stop;
    end
    initial
    begin
        #20000;
        fails++;
        report_and_stop;
    end
endmodule
`default_nettype wire
